// file: rtl/lpwm_bank.sv
// register bank and pwm outputs for 36 led channels
//
// What this block does
// - 36 eight-bit duty registers, reset zero
// - output on for duty/256 of period
// - duty at 01h-24h, control at 26h-49h
// - duty and control writes land in shadow storage first
// - writing zero to 25h copies shadows
// - control bit0 enables channel, resets zero
// - bits 2:1 scale current 1,1/2,1/3,1/4
// - 4Ah bit0 set turns every led output off
// - 4Bh bit0 picks 3kHz or 22kHz
// - writing zero to 4Fh restores defaults
// - power-up reset loads all defaults
// - 00h bit0 zero means software shutdown
// - low shutdown pin darkens, keeps registers
// - all channels share one timebase
`timescale 1ns/1ps
`default_nettype none
module lpwm_bank
  import lpwm_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                reg_wr_en,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                shutdown_pin_n,
  output logic      [NUM_CH-1:0]   led_outputs,
  output logic      [2*NUM_CH-1:0] current_scale
);
  logic [7:0] shadow_duty [NUM_CH];
  logic [7:0] active_duty [NUM_CH];
  logic [7:0] period_duty [NUM_CH];
  logic [2:0] shadow_ctrl [NUM_CH];
  logic [2:0] active_ctrl [NUM_CH];
  logic [2:0] period_ctrl [NUM_CH];
  logic       soft_shutdown_n;
  logic       global_off;
  logic       pwm_freq_select;
  logic       pin_meta;
  logic       pin_sync;
  logic       duty_hit;
  logic       ctrl_hit;
  logic       update_hit;
  logic       soft_rst_hit;
  logic [7:0] duty_idx;
  logic [7:0] ctrl_idx;
  logic [7:0] pwm_count;
  logic       period_end;
  logic       run;

  // address decode of the write port
  assign duty_hit     = reg_wr_en && (reg_addr >= DUTY_BASE) && (reg_addr <= DUTY_LAST);
  assign ctrl_hit     = reg_wr_en && (reg_addr >= CTRL_BASE) && (reg_addr <= CTRL_LAST);
  assign duty_idx     = reg_addr - DUTY_BASE;
  assign ctrl_idx     = reg_addr - CTRL_BASE;
  assign update_hit   = reg_wr_en && (reg_addr == UPDATE_OFS) && (reg_wdata == CMD_KEY);
  assign soft_rst_hit = reg_wr_en && (reg_addr == RESET_OFS) && (reg_wdata == CMD_KEY);
  // any shutdown source darkens outputs but leaves registers alone
  assign run          = soft_shutdown_n && pin_sync && !global_off;

  // shutdown pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= shutdown_pin_n;
      pin_sync <= pin_meta;
    end
  end

  // single-bit global registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      soft_shutdown_n <= FLAG_RST;
      global_off      <= FLAG_RST;
      pwm_freq_select <= FLAG_RST;
    end
    else if (soft_rst_hit)
    begin
      soft_shutdown_n <= FLAG_RST;
      global_off      <= FLAG_RST;
      pwm_freq_select <= FLAG_RST;
    end
    else if (reg_wr_en)
    begin
      if (reg_addr == SHUTDOWN_OFS)
        soft_shutdown_n <= reg_wdata[FLAG_BIT];
      if (reg_addr == GLOBAL_OFS)
        global_off <= reg_wdata[FLAG_BIT];
      if (reg_addr == FREQ_OFS)
        pwm_freq_select <= reg_wdata[FLAG_BIT];
    end
  end

  // one timebase for every channel
  lpwm_timebase u_timebase (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .clear           (soft_rst_hit),
    .pwm_freq_select (pwm_freq_select),
    .pwm_count       (pwm_count),
    .period_end      (period_end)
  );

  // per channel: shadow, active and period copies plus the output
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    // shadow storage written by the host
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        shadow_duty[ch] <= DUTY_RST;
        shadow_ctrl[ch] <= CTRL_RST;
      end
      else if (soft_rst_hit)
      begin
        shadow_duty[ch] <= DUTY_RST;
        shadow_ctrl[ch] <= CTRL_RST;
      end
      else
      begin
        if (duty_hit && duty_idx == 8'(ch))
          shadow_duty[ch] <= reg_wdata;
        if (ctrl_hit && ctrl_idx == 8'(ch))
          shadow_ctrl[ch] <= reg_wdata[SCALE_MSB:CTRL_EN_BIT];
      end
    end

    // active copy loaded only by the update command
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        active_duty[ch] <= DUTY_RST;
        active_ctrl[ch] <= CTRL_RST;
      end
      else if (soft_rst_hit)
      begin
        active_duty[ch] <= DUTY_RST;
        active_ctrl[ch] <= CTRL_RST;
      end
      else if (update_hit)
      begin
        active_duty[ch] <= shadow_duty[ch];
        active_ctrl[ch] <= shadow_ctrl[ch];
      end
    end

    // period copy taken at the period boundary to avoid glitches
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        period_duty[ch] <= DUTY_RST;
        period_ctrl[ch] <= CTRL_RST;
      end
      else if (soft_rst_hit)
      begin
        period_duty[ch] <= DUTY_RST;
        period_ctrl[ch] <= CTRL_RST;
      end
      else if (period_end)
      begin
        period_duty[ch] <= active_duty[ch];
        period_ctrl[ch] <= active_ctrl[ch];
      end
    end

    // output on while count below duty; scale passed to the driver
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        led_outputs[ch]            <= 1'b0;
        current_scale[2*ch +: 2]   <= 2'h0;
      end
      else
      begin
        led_outputs[ch] <= run && period_ctrl[ch][CTRL_EN_BIT]
                           && (pwm_count < period_duty[ch]);
        current_scale[2*ch +: 2] <= period_ctrl[ch][SCALE_MSB:SCALE_LSB];
      end
    end
  end

  default clocking bk_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence pin_held_low;
    !shutdown_pin_n [*3];
  endsequence

  sequence idle_cycle;
    !update_hit && !soft_rst_hit;
  endsequence

  zero_duty_dark_a : assert property ((period_duty[0] == 8'h00) |=> !led_outputs[0])
    else $error("channel lit with zero duty");
  duty_on_a : assert property ((run && period_ctrl[0][0] && pwm_count < period_duty[0])
                               |=> led_outputs[0])
    else $error("channel dark below its duty");
  shadow_hold_a : assert property (idle_cycle |=> $stable(active_duty[0]))
    else $error("active duty changed without update");
  update_copy_a : assert property (update_hit |=> active_duty[0] == $past(shadow_duty[0])
                                   && active_ctrl[0] == $past(shadow_ctrl[0]))
    else $error("update did not copy shadow values");
  nonzero_ignored_a : assert property ((reg_wr_en && reg_addr == UPDATE_OFS && reg_wdata != 8'h00)
                                       |=> $stable(active_ctrl[0]))
    else $error("nonzero update value was obeyed");
  ctrl_off_a : assert property (!period_ctrl[0][0] |=> !led_outputs[0])
    else $error("disabled channel lit");
  scale_out_a : assert property (1'b1 |=> current_scale[1:0] == $past(period_ctrl[0][2:1]))
    else $error("current scale does not follow control");
  global_off_a : assert property ((global_off || !soft_shutdown_n) |=> led_outputs == '0)
    else $error("outputs lit while switched off");
  soft_reset_a : assert property (soft_rst_hit |=> shadow_duty[0] == 8'h00
                                  && active_duty[0] == 8'h00 && !global_off)
    else $error("reset command left a register set");
  hw_shutdown_a : assert property (pin_held_low |=> led_outputs == '0)
    else $error("outputs lit during pin shutdown");
  boundary_a : assert property ((!period_end && !soft_rst_hit) |=> $stable(period_duty[0]))
    else $error("duty sampled inside a period");
endmodule : lpwm_bank
`default_nettype wire

// file: common/lpwm_pkg.sv
// constants for the led pwm channel bank
package lpwm_pkg;
  // clock and pwm timing
  localparam int          CLK_HZ        = 200_000_000;
  localparam int          FREQ_LOW_HZ   = 3000;
  localparam int          FREQ_HIGH_HZ  = 22000;
  localparam int          PWM_STEPS     = 256;
  localparam int          STEP_LOW_INT  = CLK_HZ / (FREQ_LOW_HZ * PWM_STEPS);
  localparam int          STEP_HIGH_INT = CLK_HZ / (FREQ_HIGH_HZ * PWM_STEPS);
  localparam logic [8:0]  STEP_CYC_LOW  = STEP_LOW_INT[8:0];
  localparam logic [8:0]  STEP_CYC_HIGH = STEP_HIGH_INT[8:0];
  localparam logic [7:0]  PWM_LAST      = 8'hff;
  // channel count
  localparam int          NUM_CH        = 36;
  // register offsets
  localparam logic [7:0]  SHUTDOWN_OFS  = 8'h00;
  localparam logic [7:0]  DUTY_BASE     = 8'h01;
  localparam logic [7:0]  DUTY_LAST     = 8'h24;
  localparam logic [7:0]  UPDATE_OFS    = 8'h25;
  localparam logic [7:0]  CTRL_BASE     = 8'h26;
  localparam logic [7:0]  CTRL_LAST     = 8'h49;
  localparam logic [7:0]  GLOBAL_OFS    = 8'h4a;
  localparam logic [7:0]  FREQ_OFS      = 8'h4b;
  localparam logic [7:0]  RESET_OFS     = 8'h4f;
  // command key and field layout
  localparam logic [7:0]  CMD_KEY       = 8'h00;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          SCALE_LSB     = 1;
  localparam int          SCALE_MSB     = 2;
  localparam int          FLAG_BIT      = 0;
  // reset values
  localparam logic [7:0]  DUTY_RST      = 8'h00;
  localparam logic [2:0]  CTRL_RST      = 3'h0;
  localparam logic        FLAG_RST      = 1'b0;
endpackage : lpwm_pkg

// file: rtl/lpwm_timebase.sv
// shared pwm step counter with selectable step rate
`timescale 1ns/1ps
`default_nettype none
module lpwm_timebase
  import lpwm_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       pwm_freq_select,
  output logic      [7:0] pwm_count,
  output logic            period_end
);
  logic [8:0] presc;
  logic [8:0] step_limit;
  logic       step_tick;

  // step length picks the period: 256 steps per period
  assign step_limit = pwm_freq_select ? STEP_CYC_HIGH : STEP_CYC_LOW;
  assign step_tick  = (presc >= step_limit - 9'h001);
  assign period_end = step_tick && (pwm_count == PWM_LAST);

  // prescaler, one enable pulse per pwm step
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      presc <= 9'h000;
    else if (clear || step_tick)
      presc <= 9'h000;
    else
      presc <= presc + 9'h001;
  end

  // pwm position within the period, wraps after 256 steps
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pwm_count <= 8'h00;
    else if (clear)
      pwm_count <= 8'h00;
    else if (step_tick)
      pwm_count <= pwm_count + 8'h01;
  end

  default clocking tb_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // prescaler restarts after every step tick
  step_len_a : assert property ((step_tick && !clear) |=> (presc == 9'h000))
    else $error("prescaler did not restart after a step");
endmodule : lpwm_timebase
`default_nettype wire

// file: test/lpwm_host.sv
// host model that writes the bank registers one byte at a time
`timescale 1ns/1ps
`default_nettype none
module lpwm_host
(
  input  wire logic       ref_clk,
  output logic            reg_wr_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle write strobe; the caller supplies the data, commands included
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_addr  = ~a; // released lines show no stale value
    reg_wdata = ~d;
  endtask : wr
endmodule : lpwm_host
`default_nettype wire

// file: test/lpwm_bank_tb.sv
// self-checking bench for the led pwm channel bank
`timescale 1ns/1ps
`default_nettype none
module lpwm_bank_tb;
  import lpwm_pkg::*;
  logic          ref_clk, rst_n, shutdown_pin_n, reg_wr_en;
  logic [7:0]    reg_addr, reg_wdata, r;
  logic [35:0]   led_outputs;
  logic [71:0]   current_scale, sc_exp;
  logic [108:0]  exp_q[$];
  logic [108:0]  e;
  logic [1:0]    sc;
  int            n_fail, check_count, w, seed;
  event          smp;
  lpwm_host host (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
                  .reg_wdata(reg_wdata));
  lpwm_bank u_lpwm_bank (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
                         .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                         .shutdown_pin_n(shutdown_pin_n), .led_outputs(led_outputs),
                         .current_scale(current_scale));
  // clock generation
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  // note an expected output state and ask the watcher to compare
  task automatic note(input logic [35:0] l, input logic [71:0] s, input logic cs);
    exp_q.push_back({cs, l, s});
    -> smp;
  endtask : note
  task automatic wait_rise(input int b);
    int n;
    n = 0;
    while (led_outputs[0] !== 1'b1 && n < b)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= b)
    begin
      n_fail++;
      conclude();
    end
  endtask : wait_rise
  task automatic width(input int ch, inout int cnt);
    while (led_outputs[ch] === 1'b1 && cnt < 70000)
    begin
      @(negedge ref_clk);
      cnt++;
    end
    // a pulse that never ends is a failure, not a long width
    if (cnt >= 70000)
    begin
      n_fail++;
      conclude();
    end
  endtask : width
  // watcher compares outputs with the oldest note
  always @(smp)
  begin
    e = exp_q.pop_front();
    check({36'h0, led_outputs}, {36'h0, e[107:72]});
    if (e[108])
      check(current_scale, e[71:0]);
  end
  initial
  begin
    seed = 32'h19008df3;
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    shutdown_pin_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    note(36'h0, 72'h0, 1'b1);
    $display("reset test done");
    r  = 8'(($unsigned($random(seed)) % 254) + 2);
    sc = 2'($random(seed));
    sc_exp = {2'b11, 68'h0, sc};
    host.wr(SHUTDOWN_OFS, 8'h01);
    host.wr(FREQ_OFS, 8'h01);
    host.wr(DUTY_BASE, r);
    host.wr(DUTY_LAST, 8'h01);
    host.wr(CTRL_BASE, {5'h1f, sc, 1'b1});
    host.wr(CTRL_LAST, 8'h07);
    repeat (9000) @(negedge ref_clk);
    note(36'h0, 72'h0, 1'b1);
    host.wr(UPDATE_OFS, 8'h05);
    repeat (9000) @(negedge ref_clk);
    note(36'h0, 72'h0, 1'b1);
    host.wr(UPDATE_OFS, CMD_KEY);
    wait_rise(20000);
    note({1'b1, 34'h0, 1'b1}, sc_exp, 1'b1);
    w = 0;
    width(35, w);
    check(72'(w), 72'(STEP_HIGH_INT));
    width(0, w);
    check(72'(w), 72'(r * STEP_HIGH_INT));
    $display("duty test done");
    host.wr(GLOBAL_OFS, 8'h01);
    repeat (3) @(negedge ref_clk);
    note(36'h0, sc_exp, 1'b0);
    host.wr(GLOBAL_OFS, 8'h00);
    host.wr(SHUTDOWN_OFS, 8'h00);
    repeat (3) @(negedge ref_clk);
    note(36'h0, sc_exp, 1'b0);
    host.wr(SHUTDOWN_OFS, 8'h01);
    shutdown_pin_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    note(36'h0, sc_exp, 1'b0);
    shutdown_pin_n = 1'b1;
    wait_rise(20000);
    note({1'b1, 34'h0, 1'b1}, sc_exp, 1'b1);
    // drop to the slow rate inside the first step; the write takes two cycles
    host.wr(FREQ_OFS, 8'h00);
    w = 2;
    width(35, w);
    check(72'(w), 72'(STEP_LOW_INT));
    $display("shutdown test done");
    foreach (r[i])
    begin
      host.wr(DUTY_BASE, 8'(i * i));
      host.wr(UPDATE_OFS, CMD_KEY);
    end
    host.wr(RESET_OFS, CMD_KEY);
    repeat (3) @(negedge ref_clk);
    note(36'h0, 72'h0, 1'b1);
    $display("reset register test done");
    conclude();
  end
endmodule : lpwm_bank_tb
`default_nettype wire
